// ===== src/config_word_protection_unit.sv
// Contract
// - Bit 13 set allows low-voltage programming entry
// - Low-voltage entry refuses clearing bit 13
// - Bit 12 clear dedicates programming pins to debugger
// - Bit 10 selects low or high brown-out trip
// - Bit 9 lets stack faults reset device
// - Bit 8 turns on clock multiplier
// - Bit 4 clear routes capacitor to port pin
// - Unimplemented word bits read as one
// - Blank or erased configuration reads all ones
// - Code protect blocks programmer writes, reads zero
// - CPU program reads unaffected; writes obey field
// - EEPROM protect blocks programmer reads and writes
// - CPU EEPROM access ignores EEPROM protect
// - Two protections independent of each other
// - Small part: code 10/01 ranges blocked
// - Large part: code 10/01 ranges blocked
// - Code 11 unprotected, code 00 fully blocked
// - Four user ID words at 8000h-8003h
// - Identification word at 8006h, read only
// - Second configuration word at 8008h
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "cfg_prot_params.svh"

module config_word_protection_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Variant and nonvolatile source
    input wire logic large_part,
    input wire logic [13:0] nv_cfg_word,
    input wire logic [6:0] nv_cfg1_prot,
    // Programming entry
    input wire logic master_clear_hv,
    input wire logic lv_entry_key,
    output logic prog_mode,
    output logic prog_mode_lv,
    // Decoded static controls
    output cfg_prot_pkg::cfg_ctrl_s ctrl,
    output logic prog_port_pins_gpio,
    // Stack fault handling
    input wire logic stack_fault,
    output logic stack_reset_req,
    // CPU program memory path
    input wire cfg_prot_pkg::mem_req_s cpu_pm,
    output logic cpu_pm_write_ok,
    // CPU data EEPROM path
    input wire cfg_prot_pkg::mem_req_s cpu_ee,
    output logic cpu_ee_access_ok,
    // Programmer program memory / config space path
    input wire cfg_prot_pkg::mem_req_s ext_pm,
    input wire logic [13:0] pm_array_rdata,
    output logic ext_pm_write_ok,
    output logic [13:0] ext_pm_rdata,
    // Programmer data EEPROM path
    input wire cfg_prot_pkg::mem_req_s ext_ee,
    input wire logic [13:0] ee_array_rdata,
    output logic ext_ee_access_ok,
    output logic [13:0] ext_ee_rdata,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    // Two-stage release so every flop leaves reset on the same edge
    logic rst_sync1_reg;
    logic rst_sync2_reg;
    wire srst_n = rst_sync2_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Configuration holder
    // ----------------------------------------------------------------
    // Reset value is blank; the array value is caught one edge after release
    cfg_prot_pkg::hold_state_e state_reg;
    logic [13:0] cfg2_reg;     // Live second configuration word
    logic [13:0] pend_reg;     // Programmed value, only readable over Wishbone; reset returns it to blank
    logic cp_n_reg;            // Program code protect, active low
    logic cpd_n_reg;           // EEPROM code protect, active low
    logic [13:0] cfg2_next;

    // Unimplemented bits forced high before anything uses the word
    assign cfg2_next = nv_cfg_word | `CFG2_UNIMPL_MASK;

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            state_reg <= cfg_prot_pkg::ST_LOAD;
            cfg2_reg <= `CFG2_BLANK;
            cp_n_reg <= 1'b1;
            cpd_n_reg <= 1'b1;
        end else begin
            unique case (state_reg)
                cfg_prot_pkg::ST_LOAD: begin
                    // Single capture; static until the next reset
                    cfg2_reg <= cfg2_next;
                    cp_n_reg <= nv_cfg1_prot[1];
                    cpd_n_reg <= nv_cfg1_prot[0];
                    state_reg <= cfg_prot_pkg::ST_RUN;
                end
                cfg_prot_pkg::ST_RUN: begin
                    state_reg <= cfg_prot_pkg::ST_RUN;
                end
            endcase
        end
    end

    wire cfg_valid = state_reg == cfg_prot_pkg::ST_RUN;

    // ----------------------------------------------------------------
    // Decoded controls
    // ----------------------------------------------------------------
    assign ctrl.low_voltage_prog_enable = cfg2_reg[`CFG2_LVP_BIT];
    assign ctrl.debugger_pins_dedicated = !cfg2_reg[`CFG2_DBG_BIT];
    assign ctrl.brownout_trip_select = cfg2_reg[`CFG2_BROWNOUT_TRIP_SELECT_BIT];
    assign ctrl.stack_fault_reset_enable = cfg2_reg[`CFG2_STV_BIT];
    assign ctrl.clock_multiplier_enable = cfg2_reg[`CFG2_PLL_BIT];
    assign ctrl.regulator_cap_on_pin = !cfg2_reg[`CFG2_REGULATOR_CAP_PIN_BIT];
    assign ctrl.self_write_protect_field = cfg2_reg[`CFG2_WRT_HI:`CFG2_WRT_LO];
    assign prog_port_pins_gpio = cfg2_reg[`CFG2_DBG_BIT];
    // Stack faults only reset when enabled
    assign stack_reset_req = stack_fault && cfg2_reg[`CFG2_STV_BIT];

    // ----------------------------------------------------------------
    // Programming mode entry
    // ----------------------------------------------------------------
    // High voltage always works; the key only when low-voltage is enabled
    wire lv_entry = lv_entry_key && ctrl.low_voltage_prog_enable;
    logic pm_reg;
    logic pm_lv_reg;

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            pm_reg <= 1'b0;
            pm_lv_reg <= 1'b0;
        end else if (!pm_reg && cfg_valid && (master_clear_hv || lv_entry)) begin
            pm_reg <= 1'b1;
            pm_lv_reg <= !master_clear_hv;
        end
    end

    assign prog_mode = pm_reg;
    assign prog_mode_lv = pm_lv_reg;

    // ----------------------------------------------------------------
    // Programmer access to config space and program memory
    // ----------------------------------------------------------------
    wire ext_cfg_space = ext_pm.addr[`CFG_SPACE_BIT];
    wire ext_uid_hit = ext_cfg_space && ext_pm.addr >= `ADDR_USER_ID_BASE
                       && ext_pm.addr <= `ADDR_USER_ID_LAST;
    wire ext_pid_hit = ext_pm.addr == `ADDR_PART_ID;
    wire ext_cfg2_hit = ext_pm.addr == `ADDR_CFG_WORD2;
    wire [13:0] part_word = {`PART_ID_VALUE, `REV_ID_VALUE};

    // New value for the pending word; low-voltage entry keeps bit 13 set
    logic [13:0] pend_wdata;
    always_comb begin
        pend_wdata = ext_pm.wdata | `CFG2_UNIMPL_MASK;
        if (pm_lv_reg) begin
            pend_wdata[`CFG2_LVP_BIT] = 1'b1;
        end
    end

    // Array writes only when code protect is off (bit 1 of nv_cfg1_prot)
    assign ext_pm_write_ok = ext_pm.req && ext_pm.wr && pm_reg && !ext_cfg_space
                             && cp_n_reg;

    wire pend_we = ext_pm.req && ext_pm.wr && pm_reg && ext_cfg2_hit;
    wire uid_ext_we = ext_pm.req && ext_pm.wr && pm_reg && ext_uid_hit;

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            pend_reg <= `CFG2_BLANK;
        end else if (pend_we) begin
            pend_reg <= pend_wdata;
        end
    end

    // ----------------------------------------------------------------
    // User ID words
    // ----------------------------------------------------------------
    // CPU reaches them through the config space too (bit 15 of address)
    wire cpu_uid_hit = cpu_pm.addr >= `ADDR_USER_ID_BASE
                       && cpu_pm.addr <= `ADDR_USER_ID_LAST;
    wire cpu_uid_we = cpu_pm.req && cpu_pm.wr && cpu_uid_hit;
    wire wb_uid_hit;
    wire wb_uid_we;
    wire uid_we = uid_ext_we || cpu_uid_we || wb_uid_we;
    wire [1:0] uid_waddr = uid_ext_we ? ext_pm.addr[1:0]
                         : cpu_uid_we ? cpu_pm.addr[1:0] : wb_adr_i[3:2];
    wire [13:0] uid_wdata = uid_ext_we ? ext_pm.wdata
                          : cpu_uid_we ? cpu_pm.wdata : wb_dat_i[13:0];
    wire [1:0] uid_raddr = wb_uid_hit ? wb_adr_i[3:2] : ext_pm.addr[1:0];
    logic [13:0] uid_rdata;

    user_id_mem u_uid (
        .clk(clk),
        .rst_n(srst_n),
        .we(uid_we),
        .waddr(uid_waddr),
        .wdata(uid_wdata),
        .raddr(uid_raddr),
        .rdata(uid_rdata)
    );

    // ----------------------------------------------------------------
    // Programmer read data
    // ----------------------------------------------------------------
    // Registered one cycle after the request, matching the ID memory
    logic ext_uid_rd_reg;
    logic [13:0] ext_pm_rd_reg;
    logic [13:0] ext_pm_sel;

    always_comb begin
        if (ext_cfg2_hit) begin
            ext_pm_sel = cfg2_reg;
        end else if (ext_pid_hit) begin
            ext_pm_sel = part_word;
        end else if (ext_cfg_space) begin
            ext_pm_sel = 14'h0000;
        end else if (cp_n_reg) begin
            ext_pm_sel = pm_array_rdata;
        end else begin
            ext_pm_sel = 14'h0000;
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            ext_pm_rd_reg <= 14'h0000;
            ext_uid_rd_reg <= 1'b0;
        end else begin
            ext_pm_rd_reg <= ext_pm_sel;
            ext_uid_rd_reg <= ext_uid_hit && !wb_uid_hit;
        end
    end

    assign ext_pm_rdata = ext_uid_rd_reg ? uid_rdata : ext_pm_rd_reg;

    // ----------------------------------------------------------------
    // Data EEPROM gating
    // ----------------------------------------------------------------
    // Programmer side obeys only the EEPROM protect bit
    assign ext_ee_access_ok = ext_ee.req && pm_reg && cpd_n_reg;

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            ext_ee_rdata <= 14'h0000;
        end else begin
            ext_ee_rdata <= cpd_n_reg ? ee_array_rdata : 14'h0000;
        end
    end

    // CPU side never sees either code protect bit
    assign cpu_ee_access_ok = cpu_ee.req;

    // ----------------------------------------------------------------
    // CPU self-write protection
    // ----------------------------------------------------------------
    logic wrt_blocked;

    wrt_decode u_wrt (
        .field(ctrl.self_write_protect_field),
        .large_part(large_part),
        .addr(cpu_pm.addr[13:0]),
        .blocked(wrt_blocked)
    );

    // Reads need no permission; writes depend on the field and are refused in config space (bit 15)
    assign cpu_pm_write_ok = cpu_pm.req && cpu_pm.wr && !cpu_pm.addr[`CFG_SPACE_BIT]
                             && !wrt_blocked;

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    // One-cycle answer; ack drops the cycle after it was given
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wb_uid_hit = wb_req && wb_adr_i[7:4] == 4'(`REG_USER_ID0 >> 4)
                        && wb_adr_i[1:0] == 2'b00;
    wire hit_cur = wb_adr_i == `REG_CFG2_CUR;
    wire hit_pend = wb_adr_i == `REG_CFG2_PEND;
    wire hit_pid = wb_adr_i == `REG_PART_ID;
    wire hit_stat = wb_adr_i == `REG_STATUS;
    wire wb_mapped = hit_cur || hit_pend || hit_pid || hit_stat || wb_uid_hit;
    // Live word and ID register are read only; writes ignored silently
    assign wb_uid_we = wb_uid_hit && wb_we_i && wb_sel_i[0] && wb_sel_i[1];
    wire [31:0] wb_stat = {28'h0000000, cpd_n_reg, cp_n_reg, pm_lv_reg, pm_reg};
    wire wb_uid_rd = wb_uid_hit && !wb_we_i;
    logic wb_uid_rd_reg;
    logic [31:0] wb_dat_reg;
    logic [31:0] wb_sel_data;

    always_comb begin
        if (hit_cur) begin
            wb_sel_data = {18'h00000, cfg2_reg};
        end else if (hit_pend) begin
            wb_sel_data = {18'h00000, pend_reg};
        end else if (hit_pid) begin
            wb_sel_data = {18'h00000, part_word};
        end else if (hit_stat) begin
            wb_sel_data = wb_stat;
        end else begin
            wb_sel_data = 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_reg <= 32'h00000000;
            wb_uid_rd_reg <= 1'b0;
        end else begin
            wb_ack_o <= wb_req && wb_mapped;
            wb_err_o <= wb_req && !wb_mapped;
            wb_dat_reg <= wb_sel_data;
            wb_uid_rd_reg <= wb_uid_rd;
        end
    end

    assign wb_dat_o = wb_uid_rd_reg ? {18'h00000, uid_rdata} : wb_dat_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_lv_entered;
        pm_reg && pm_lv_reg;
    endsequence

    chk_lv_entry_gate: assert property (@(posedge clk) disable iff (!srst_n)
        $rose(pm_reg) && !$past(master_clear_hv) |-> $past(ctrl.low_voltage_prog_enable))
        else $error("low-voltage entry while disabled");
    chk_lv_bit_kept: assert property (@(posedge clk) disable iff (!srst_n)
        s_lv_entered ##0 pend_we |=> pend_reg[`CFG2_LVP_BIT])
        else $error("low-voltage bit cleared");
    chk_pins_debug: assert property (@(posedge clk) disable iff (!srst_n)
        prog_port_pins_gpio != ctrl.debugger_pins_dedicated)
        else $error("debug pin mode mismatch");
    chk_stack_reset: assert property (@(posedge clk) disable iff (!srst_n)
        stack_reset_req == (stack_fault && ctrl.stack_fault_reset_enable))
        else $error("stack reset gating wrong");
    chk_unimpl_ones: assert property (@(posedge clk) disable iff (!srst_n)
        (cfg2_reg & `CFG2_UNIMPL_MASK) == `CFG2_UNIMPL_MASK)
        else $error("unimplemented bits not one");
    chk_cfg_static: assert property (@(posedge clk) disable iff (!srst_n)
        cfg_valid ##1 cfg_valid |-> $stable(cfg2_reg))
        else $error("configuration changed");
    chk_cp_read_zero: assert property (@(posedge clk) disable iff (!srst_n)
        !cp_n_reg && !ext_pm.addr[`CFG_SPACE_BIT] |=> ext_pm_rdata == 14'h0000)
        else $error("protected read leaked");
    chk_cp_no_write: assert property (@(posedge clk) disable iff (!srst_n)
        !cp_n_reg |-> !ext_pm_write_ok)
        else $error("protected write allowed");
    chk_ee_block: assert property (@(posedge clk) disable iff (!srst_n)
        !cpd_n_reg |-> !ext_ee_access_ok ##1 ext_ee_rdata == 14'h0000)
        else $error("protected eeprom access");
    chk_wrt_full: assert property (@(posedge clk) disable iff (!srst_n)
        ctrl.self_write_protect_field == 2'b00 |-> !cpu_pm_write_ok)
        else $error("self-write not blocked");
    chk_wrt_boot: assert property (@(posedge clk) disable iff (!srst_n)
        ctrl.self_write_protect_field == 2'b10 && cpu_pm.req && cpu_pm.wr
        && !cpu_pm.addr[15] && cpu_pm.addr[13:0] > `WRT_BOOT_LAST |-> cpu_pm_write_ok)
        else $error("boot range decode wrong");

endmodule : config_word_protection_unit
`default_nettype wire

// ===== src/cfg_prot_params.svh
`ifndef CFG_PROT_PARAMS_SVH
`define CFG_PROT_PARAMS_SVH

// ----------------------------------------------------------------
// Configuration-space word addresses
// ----------------------------------------------------------------
`define ADDR_USER_ID_BASE 16'h8000
`define ADDR_USER_ID_LAST 16'h8003
`define ADDR_PART_ID 16'h8006
`define ADDR_CFG_WORD2 16'h8008
`define CFG_SPACE_BIT 15

// ----------------------------------------------------------------
// Second configuration word field positions
// ----------------------------------------------------------------
`define CFG2_LVP_BIT 13
`define CFG2_DBG_BIT 12
`define CFG2_BROWNOUT_TRIP_SELECT_BIT 10
`define CFG2_STV_BIT 9
`define CFG2_PLL_BIT 8
`define CFG2_REGULATOR_CAP_PIN_BIT 4
`define CFG2_WRT_HI 1
`define CFG2_WRT_LO 0
// Unimplemented positions, forced to one on every read
`define CFG2_UNIMPL_MASK 14'h08EC
// Blank / bulk-erased value
`define CFG2_BLANK 14'h3FFF
`define CFG2_WRITABLE_MASK 14'h3713

// ----------------------------------------------------------------
// Self-write protection limits (last protected word)
// ----------------------------------------------------------------
`define WRT_BOOT_LAST 14'h01FF
`define WRT_HALF8K_LAST 14'h0FFF
`define WRT_HALF16K_LAST 14'h1FFF
`define WRT_FULL8K_LAST 14'h1FFF
`define WRT_FULL16K_LAST 14'h3FFF

// ----------------------------------------------------------------
// Identification word layout and arbitrary values
// ----------------------------------------------------------------
`define PART_ID_LSB 5
`define PART_ID_VALUE 9'h0A5
`define REV_ID_VALUE 5'h03

// ----------------------------------------------------------------
// Register bus map (byte addresses)
// ----------------------------------------------------------------
`define REG_CFG2_CUR 8'h00
`define REG_CFG2_PEND 8'h04
`define REG_PART_ID 8'h08
`define REG_STATUS 8'h0C
`define REG_USER_ID0 8'h10

`endif

// ===== src/cfg_prot_pkg.sv
package cfg_prot_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Decoded static controls handed to dependent blocks
    typedef struct packed {
        logic low_voltage_prog_enable;
        logic debugger_pins_dedicated;
        logic brownout_trip_select;
        logic stack_fault_reset_enable;
        logic clock_multiplier_enable;
        logic regulator_cap_on_pin;
        logic [1:0] self_write_protect_field;
    } cfg_ctrl_s;

    // One program-memory or EEPROM access request
    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [13:0] wdata;
    } mem_req_s;

    // Latching state of the configuration holder
    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } hold_state_e;

endpackage : cfg_prot_pkg

// ===== src/user_id_mem.sv
`timescale 1ns/1ns
`default_nettype none
`include "cfg_prot_params.svh"

module user_id_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic we,
    input wire logic [1:0] waddr,
    input wire logic [13:0] wdata,
    // Read port
    input wire logic [1:0] raddr,
    output logic [13:0] rdata
);

    // ----------------------------------------------------------------
    // Storage: four 14-bit ID locations, blank value after reset
    // ----------------------------------------------------------------
    logic [13:0] mem_reg [4];

    generate
        for (genvar i = 0; i < 4; i++) begin : g_word
            // Each word loads only on its own write
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_reg[i] <= 14'h3FFF;
                end else if (we && waddr == 2'(i)) begin
                    mem_reg[i] <= wdata;
                end
            end
        end
    endgenerate

    // Registered read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 14'h0000;
        end else begin
            rdata <= mem_reg[raddr];
        end
    end

endmodule : user_id_mem
`default_nettype wire

// ===== src/wrt_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "cfg_prot_params.svh"

module wrt_decode (
    // Configuration
    input wire logic [1:0] field,
    input wire logic large_part,
    // Address under test
    input wire logic [13:0] addr,
    output logic blocked
);

    // ----------------------------------------------------------------
    // Protected range decode
    // ----------------------------------------------------------------
    // Last protected word for the current code and variant
    wire [13:0] half_last = large_part ? `WRT_HALF16K_LAST : `WRT_HALF8K_LAST;
    wire in_boot = addr <= `WRT_BOOT_LAST;
    wire in_half = addr <= half_last;

    always_comb begin
        unique case (field)
            2'b11: blocked = 1'b0;
            2'b10: blocked = in_boot;
            2'b01: blocked = in_half;
            // Whole array: words past the small part's end are refused too
            2'b00: blocked = 1'b1;
        endcase
    end

endmodule : wrt_decode
`default_nettype wire

// ===== tb/prog_tool_model.sv
`timescale 1ns/1ns
`default_nettype none
module prog_tool_model (
    // Clock
    input wire logic clk,
    // Requests toward the device
    output var cfg_prot_pkg::mem_req_s ext_pm,
    output var cfg_prot_pkg::mem_req_s ext_ee,
    // Array contents that protection must hide
    output logic [13:0] pm_rd,
    output logic [13:0] ee_rd
);
    assign pm_rd = 14'h2AAA;
    assign ee_rd = 14'h1555;
    initial begin
        ext_pm = '0;
        ext_ee = '0;
    end
    // One request held over a single edge, then released
    task automatic access(input logic ee, input logic w, input logic [15:0] a,
                          input logic [13:0] d);
        cfg_prot_pkg::mem_req_s r;
        r = '{req: 1'b1, wr: w, addr: a, wdata: d};
        @(posedge clk);
        if (ee) ext_ee <= r;
        else ext_pm <= r;
        @(posedge clk);
        ext_pm <= '0;
        ext_ee <= '0;
    endtask : access
endmodule : prog_tool_model
`default_nettype wire

// ===== tb/config_word_protection_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module config_word_protection_unit_tb;
    logic clk, rst_n, lg, hv, key, sf, cyc, stb, we, ack, err, e;
    logic gpio, srst, pmm, pml, cwok, ceok, xwok, xeok;
    logic [13:0] cfg, pm_rd, ee_rd, xprd, xerd;
    logic [6:0] prot;
    logic [7:0] adr;
    logic [31:0] di, dout, q;
    cfg_prot_pkg::mem_req_s cpm, cee, xpm, xee;
    cfg_prot_pkg::cfg_ctrl_s ctrl;
    int miscompares = 0, n_tests = 0;
    config_word_protection_unit i_dut (.clk(clk), .rst_n(rst_n), .large_part(lg),
        .nv_cfg_word(cfg), .nv_cfg1_prot(prot), .master_clear_hv(hv), .lv_entry_key(key),
        .prog_mode(pmm), .prog_mode_lv(pml), .ctrl(ctrl), .prog_port_pins_gpio(gpio),
        .stack_fault(sf), .stack_reset_req(srst), .cpu_pm(cpm), .cpu_pm_write_ok(cwok),
        .cpu_ee(cee), .cpu_ee_access_ok(ceok), .ext_pm(xpm), .pm_array_rdata(pm_rd),
        .ext_pm_write_ok(xwok), .ext_pm_rdata(xprd), .ext_ee(xee), .ee_array_rdata(ee_rd),
        .ext_ee_access_ok(xeok), .ext_ee_rdata(xerd), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(di), .wb_dat_o(dout),
        .wb_ack_o(ack), .wb_err_o(err));
    prog_tool_model i_tool (.clk(clk), .ext_pm(xpm), .ext_ee(xee), .pm_rd(pm_rd),
        .ee_rd(ee_rd));
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    // Reset with a new nonvolatile image; first request only after edge 4
    task automatic boot(input logic [13:0] c, input logic [6:0] p, input logic l);
        @(posedge clk);
        rst_n <= 1'b0;
        cfg <= c;
        prot <= p;
        lg <= l;
        hv <= 1'b0;
        key <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : boot
    // Classic cycle: hold until ack or err is seen at an edge
    // No limit of its own: a hung wait is ended by the watchdog
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, di} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        q = dout;
        e = err;
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    task automatic cpu(input logic [15:0] a, input logic ok);
        @(posedge clk);
        cpm <= '{req: 1'b1, wr: 1'b1, addr: a, wdata: 14'h0000};
        @(posedge clk);
        chk("cpu write", ok, cwok);
    endtask : cpu
    // Programmer access; grant in the held cycle, read data one cycle later
    task automatic ext(input logic ee, input logic w, input logic [15:0] a,
                       input logic ok, input logic [13:0] rd);
        fork
            i_tool.access(ee, w, a, 14'h0000);
            begin
                @(posedge clk);
                @(negedge clk);
                chk("ext grant", ok, ee ? xeok : xwok);
                @(negedge clk);
                if (!w) chk("ext data", rd, ee ? xerd : xprd);
            end
        join
    endtask : ext
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial begin
        {rst_n, lg, hv, key, sf, cyc, stb, we, adr, di, cfg, prot} = '0;
        cpm = '0;
        cee = '{req: 1'b1, wr: 1'b1, addr: 16'h0000, wdata: 14'h0000};
        boot(14'h0000, 7'h7E, 1'b0);
        sf <= 1'b1;
        chk("ctrl", 8'h44, ctrl);
        chk("gpio", 1'b0, gpio);
        wb(1'b0, 8'h00, 32'h0);
        chk("cfg read", 32'h08EC, q);
        chk("stack", 1'b0, srst);
        cpu(16'h0000, 1'b0);
        key <= 1'b1;
        repeat (3) @(posedge clk);
        chk("lv refused", 1'b0, pmm);
        hv <= 1'b1;
        repeat (3) @(posedge clk);
        ext(1'b0, 1'b0, 16'h8008, 1'b0, 14'h08EC);
        ext(1'b0, 1'b1, 16'h0010, 1'b1, 14'h0);
        ext(1'b0, 1'b0, 16'h0010, 1'b0, 14'h2AAA);
        ext(1'b1, 1'b0, 16'h0010, 1'b0, 14'h0000);
        chk("cpu ee", 1'b1, ceok);
        boot(14'h3FFF, 7'h7D, 1'b1);
        chk("blank ctrl", 8'hBB, ctrl);
        chk("stack", 1'b1, srst);
        wb(1'b1, 8'h08, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        chk("id word", 32'h14A3, q);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 1'b1, e);
        wb(1'b1, 8'h10, 32'h0123);
        wb(1'b0, 8'h10, 32'h0);
        chk("user id", 32'h0123, q);
        cpu(16'h3FFF, 1'b1);
        key <= 1'b1;
        repeat (3) @(posedge clk);
        chk("lv mode", 2'b11, {pmm, pml});
        ext(1'b0, 1'b1, 16'h0010, 1'b0, 14'h0);
        ext(1'b0, 1'b0, 16'h0010, 1'b0, 14'h0000);
        ext(1'b1, 1'b0, 16'h0010, 1'b1, 14'h1555);
        // Config-space write: array grant stays low, pending word takes it
        ext(1'b0, 1'b1, 16'h8008, 1'b0, 14'h0);
        wb(1'b0, 8'h04, 32'h0);
        chk("pending", 32'h28EC, q);
        for (int i = 0; i < 4; i++) begin
            boot({12'hFFF, (i % 2) ? 2'b01 : 2'b10}, 7'h7F, i / 2);
            q = (i % 2) ? ((i / 2) ? 32'h1FFF : 32'h0FFF) : 32'h01FF;
            cpu(q[15:0], 1'b0);
            cpu(q[15:0] + 16'h1, 1'b1);
        end
        print_verdict();
    end
endmodule : config_word_protection_unit_tb
`default_nettype wire
